// >>> rtl/pin_ctl_if.sv
// Carrier between the configuration registers and the pad driver.
// Assumes one clock domain; all signals are per pin, one bit each except mode, a three-bit pin_mode_t.
`timescale 1ns/1ps
`include "port_cfg_consts.svh"
interface pin_ctl_if;
   import port_cfg_pkg::*;
   pin_mode_t mode [`NUM_PINS]; // Decoded pad behaviour
   logic [`NUM_PINS-1:0] dout; // Port data to drive
   logic [`NUM_PINS-1:0] alt; // Alternate function source
   logic [`NUM_PINS-1:0] pad_out; // Pad output level
   logic [`NUM_PINS-1:0] pad_oe; // Pad output enable
   logic [`NUM_PINS-1:0] pad_pu; // Pull-up enable
   logic [`NUM_PINS-1:0] pad_pd; // Pull-down enable
   logic [`NUM_PINS-1:0] pad_ana; // Analog switch enable
   logic [`NUM_PINS-1:0] ibuf_en; // Digital input buffer enable
   modport ctl (output mode, dout, alt, input pad_out, pad_oe, pad_pu, pad_pd, pad_ana, ibuf_en);
   modport drv (input mode, dout, alt, output pad_out, pad_oe, pad_pu, pad_pd, pad_ana, ibuf_en);
endinterface : pin_ctl_if

// >>> rtl/pin_drive.sv
// Pad driver: turns each pin's decoded mode into registered pad controls.
// Assumes mode, dout and alt are stable synchronous values from the
// configuration logic; every pad control leaves here from a flip-flop.
`timescale 1ns/1ps
`include "port_cfg_consts.svh"
module pin_drive (
   input wire logic clk, // System clock
   input wire logic srst, // Synchronous reset, active high
   pin_ctl_if.drv pins // Mode in, pad controls out
);
   import port_cfg_pkg::*;

   // One identical cell per pin
   for (genvar i = 0; i < `NUM_PINS; i++) begin : g_pin
      // Reset leaves every pad an undriven, unpulled input
      always_ff @(posedge clk) begin
         if (srst) begin
            pins.pad_out[i] <= 1'b0;
            pins.pad_oe[i] <= 1'b0;
            pins.pad_pu[i] <= 1'b0;
            pins.pad_pd[i] <= 1'b0;
            pins.pad_ana[i] <= 1'b0;
            pins.ibuf_en[i] <= 1'b1;
         end else begin
            pins.pad_out[i] <= 1'b0;
            pins.pad_oe[i] <= 1'b0;
            pins.pad_pu[i] <= 1'b0;
            pins.pad_pd[i] <= 1'b0;
            pins.pad_ana[i] <= 1'b0;
            pins.ibuf_en[i] <= 1'b1;
            case (pins.mode[i])
               PM_IN: begin
               end
               PM_IN_PU: begin
                  pins.pad_pu[i] <= 1'b1;
               end
               PM_IN_PD: begin
                  pins.pad_pd[i] <= 1'b1;
               end
               // Buffer off so a mid-rail level burns no current
               PM_ANALOG: begin
                  pins.pad_ana[i] <= 1'b1;
                  pins.ibuf_en[i] <= 1'b0;
               end
               PM_PUSH_PULL: begin
                  pins.pad_out[i] <= pins.dout[i];
                  pins.pad_oe[i] <= 1'b1;
               end
               // Open drain only pulls low; a one releases the pad
               PM_OPEN_DRAIN: begin
                  pins.pad_oe[i] <= ~pins.dout[i];
               end
               PM_OPEN_DRAIN_PU: begin
                  pins.pad_oe[i] <= ~pins.dout[i];
                  pins.pad_pu[i] <= 1'b1;
               end
               PM_ALT_OUT: begin
                  pins.pad_out[i] <= pins.alt[i];
                  pins.pad_oe[i] <= 1'b1;
               end
               default: begin
               end
            endcase
         end
      end
   end
endmodule : pin_drive

// >>> rtl/port_cfg_consts.svh
// Named constants of the port configuration block: register indices,
// field ranges, mode encodings, reset values and pin numbering.
// Assumes the includer wants plain text macros; holds no logic.
`ifndef PORT_CFG_CONSTS_SVH
`define PORT_CFG_CONSTS_SVH
// Register indices; the bus byte address is four times the index
`define REG_P0MODE_IDX 8'he7
`define REG_P0FLAGS_IDX 8'he8
`define REG_P1CTL_IDX 8'he9
`define REG_P2HI_IDX 8'hea
`define REG_P2LO_IDX 8'heb
`define REG_EVT_STAT_IDX 8'he0
`define REG_EVT_MASK_IDX 8'he1
`define ADDR_W 10
`define NUM_PINS 11
`define NUM_SRC 2
// Reset values
`define RST_BYTE 8'h00
`define RST_MODE 4'h0
`define RST_P2HI 7'h00
`define RST_EVT 2'h0
`define RST_PINS 11'h000
`define RST_WORD 32'h0000_0000
// Flag register bit positions
`define BIT_EN1 3
`define BIT_PEND1 2
`define BIT_EN0 1
`define BIT_PEND0 0
// Port 1 open-drain bits and the pin fields of ports 0, 1 and 2, 2-bit except the 3-bit port 2 pin 6 field
`define P1_OD1_BIT 7
`define P1_OD0_BIT 6
`define P1_PIN1_F 3:2
`define P1_PIN0_F 1:0
`define P0_PIN1_F 3:2
`define P0_PIN0_F 1:0
`define P2H_PIN6_F 6:4
`define P2H_PIN5_F 3:2
`define P2H_PIN4_F 1:0
`define P2L_PIN3_F 7:6
`define P2L_PIN2_F 5:4
`define P2L_PIN1_F 3:2
`define P2L_PIN0_F 1:0
// Two-bit codes
`define M2_00 2'h0
`define M2_01 2'h1
`define M2_10 2'h2
`define M2_11 2'h3
// Three-bit codes for port 2 pin 6
`define M3_PU 3'h0
`define M3_IN 3'h1
`define M3_PP 3'h4
`define M3_ODPU 3'h5
`define M3_OD 3'h6
`define M3_CLK 3'h7
// Pin numbering on the flat pad vectors
`define PIN_P0_0 0
`define PIN_P0_1 1
`define PIN_P1_0 2
`define PIN_P1_1 3
`define PIN_P2_0 4
`define PIN_P2_3 7
`define PIN_P2_5 9
`define PIN_P2_6 10
`endif

// >>> rtl/port_cfg_pkg.sv
// Types shared by the port configuration block and its pad driver.
// Assumes the constants header is available to whoever includes it.
package port_cfg_pkg;
   // Electrical behaviour of one pad
   typedef enum logic [2:0] {
      PM_IN,            // Schmitt input, no pull
      PM_IN_PU,         // Schmitt input with pull-up
      PM_IN_PD,         // Schmitt input with pull-down
      PM_ANALOG,        // Analog input, input buffer off
      PM_PUSH_PULL,     // Driven both ways from port data
      PM_OPEN_DRAIN,    // Low side only
      PM_OPEN_DRAIN_PU, // Low side only, pull-up on
      PM_ALT_OUT        // Push-pull from the alternate source
   } pin_mode_t;
endpackage : port_cfg_pkg

// >>> rtl/port_config_ext_int.sv
// Pin configuration for ports 0, 1 and 2 with two falling-edge sources.
// Assumes an Avalon-MM master on the system clock, pad inputs already
// synchronous to clk, and port data, timer match and clock-out sources
// supplied by neighbouring blocks.
`timescale 1ns/1ps
`include "port_cfg_consts.svh"

module port_config_ext_int (
   input wire logic clk, // System clock, 40 MHz
   input wire logic srst, // Synchronous reset, active high
   input wire logic [`ADDR_W-1:0] avs_address, // Byte address
   input wire logic avs_read, // Read request
   input wire logic avs_write, // Write request
   input wire logic [31:0] avs_writedata, // Write data
   input wire logic [3:0] avs_byteenable, // Byte lanes
   output logic [31:0] avs_readdata, // Read data
   output logic avs_waitrequest, // Stall while high
   input wire logic [`NUM_PINS-1:0] pad_in, // Pad levels
   output logic [`NUM_PINS-1:0] pad_out, // Pad drive level
   output logic [`NUM_PINS-1:0] pad_oe, // Pad drive enable
   output logic [`NUM_PINS-1:0] pad_pu, // Pull-up enables
   output logic [`NUM_PINS-1:0] pad_pd, // Pull-down enables
   output logic [`NUM_PINS-1:0] pad_ana, // Analog switch enables
   output logic [`NUM_PINS-1:0] pad_ibuf_en, // Input buffer enables
   output logic [`NUM_PINS-1:0] pin_din, // Sampled pad levels
   input wire logic [`NUM_PINS-1:0] pin_dout, // Port data latches
   input wire logic timer_zero_match_out, // Timer match level
   input wire logic clk_out_src, // Clock for the clock-out function
   output logic ext_req, // External source request
   output logic irq // Event interrupt, level
);
   import port_cfg_pkg::*;

   pin_ctl_if pins (); // Decoded modes to the pad driver

   logic [3:0] port0_pin_mode; // Mode fields of port 0 pins 1 and 0
   logic [3:0] port0_ext_irq_flags; // Enables and pending flags
   logic [7:0] port1_pin_control; // Port 1 control
   logic [6:0] port2_upper_pin_control; // Port 2 pins 6..4
   logic [7:0] port2_lower_pin_control; // Port 2 pins 3..0
   logic [`NUM_SRC-1:0] evt_status; // Sticky edge events
   logic [`NUM_SRC-1:0] evt_mask; // Event interrupt mask
   logic [`NUM_PINS-1:0] din_prev; // Previous sampled levels
   logic [`NUM_SRC-1:0] fall; // Sensed falling edges
   logic [`NUM_SRC-1:0] sensing; // Source pin in sensing mode
   logic req; // Bus request present
   logic fire; // Bus access completes this edge
   logic wr_fire; // Write completes this edge
   logic lane0; // Low byte lane written
   logic [7:0] wbyte; // Low byte of write data
   logic [31:0] next_readdata; // Read mux
   logic [`ADDR_W-1:0] a_p0mode; // Byte addresses of each register
   logic [`ADDR_W-1:0] a_p0flags;
   logic [`ADDR_W-1:0] a_p1ctl;
   logic [`ADDR_W-1:0] a_p2hi;
   logic [`ADDR_W-1:0] a_p2lo;
   logic [`ADDR_W-1:0] a_stat;
   logic [`ADDR_W-1:0] a_mask;

   assign a_p0mode = {`REG_P0MODE_IDX, 2'b00};
   assign a_p0flags = {`REG_P0FLAGS_IDX, 2'b00};
   assign a_p1ctl = {`REG_P1CTL_IDX, 2'b00};
   assign a_p2hi = {`REG_P2HI_IDX, 2'b00};
   assign a_p2lo = {`REG_P2LO_IDX, 2'b00};
   assign a_stat = {`REG_EVT_STAT_IDX, 2'b00};
   assign a_mask = {`REG_EVT_MASK_IDX, 2'b00};

   // Bus handshake terms
   assign req = avs_read | avs_write;
   assign fire = req & ~avs_waitrequest;
   assign wr_fire = avs_write & ~avs_waitrequest;
   assign lane0 = avs_byteenable[0];
   assign wbyte = avs_writedata[7:0];

   // Port 0 pins: input sensing, pull-up, output or analog
   function automatic pin_mode_t dec_p0(input logic [1:0] f);
      case (f)
         `M2_00: dec_p0 = PM_IN;
         `M2_01: dec_p0 = PM_IN_PU;
         `M2_10: dec_p0 = PM_PUSH_PULL;
         default: dec_p0 = PM_ANALOG;
      endcase
   endfunction : dec_p0

   // Port 1 pins: open-drain bit only matters in output mode
   function automatic pin_mode_t dec_p1(input logic od, input logic [1:0] f);
      case (f)
         `M2_00: dec_p1 = PM_IN;
         `M2_01: dec_p1 = PM_IN_PU;
         `M2_10: dec_p1 = od ? PM_OPEN_DRAIN : PM_PUSH_PULL;
         default: dec_p1 = PM_IN_PD;
      endcase
   endfunction : dec_p1

   // Port 2 two-bit pins; pin 0 swaps open drain for the timer output
   function automatic pin_mode_t dec_p2(input logic [1:0] f, input logic alt_pin);
      case (f)
         `M2_00: dec_p2 = PM_IN_PU;
         `M2_01: dec_p2 = PM_IN;
         `M2_10: dec_p2 = PM_PUSH_PULL;
         default: dec_p2 = alt_pin ? PM_ALT_OUT : PM_OPEN_DRAIN;
      endcase
   endfunction : dec_p2

   // Port 2 pin 6 three-bit field; both 01x codes mean analog
   function automatic pin_mode_t dec_p26(input logic [2:0] f);
      case (f)
         `M3_PU: dec_p26 = PM_IN_PU;
         `M3_IN: dec_p26 = PM_IN;
         `M3_PP: dec_p26 = PM_PUSH_PULL;
         `M3_ODPU: dec_p26 = PM_OPEN_DRAIN_PU;
         `M3_OD: dec_p26 = PM_OPEN_DRAIN;
         `M3_CLK: dec_p26 = PM_ALT_OUT;
         default: dec_p26 = PM_ANALOG;
      endcase
   endfunction : dec_p26

   // Mode decode for every pin
   always_comb begin
      pins.mode[`PIN_P0_0] = dec_p0(port0_pin_mode[`P0_PIN0_F]);
      pins.mode[`PIN_P0_1] = dec_p0(port0_pin_mode[`P0_PIN1_F]);
      // open-drain and mode of pin zero
      pins.mode[`PIN_P1_0] = dec_p1(port1_pin_control[`P1_OD0_BIT], port1_pin_control[`P1_PIN0_F]);
      // open-drain and mode of pin one
      pins.mode[`PIN_P1_1] = dec_p1(port1_pin_control[`P1_OD1_BIT], port1_pin_control[`P1_PIN1_F]);
      pins.mode[`PIN_P2_0] = dec_p2(port2_lower_pin_control[`P2L_PIN0_F], 1'b1);
      pins.mode[`PIN_P2_0+1] = dec_p2(port2_lower_pin_control[`P2L_PIN1_F], 1'b0);
      pins.mode[`PIN_P2_0+2] = dec_p2(port2_lower_pin_control[`P2L_PIN2_F], 1'b0);
      pins.mode[`PIN_P2_3] = dec_p2(port2_lower_pin_control[`P2L_PIN3_F], 1'b0);
      pins.mode[`PIN_P2_3+1] = dec_p2(port2_upper_pin_control[`P2H_PIN4_F], 1'b0);
      pins.mode[`PIN_P2_5] = dec_p2(port2_upper_pin_control[`P2H_PIN5_F], 1'b0);
      pins.mode[`PIN_P2_6] = dec_p26(port2_upper_pin_control[`P2H_PIN6_F]);
   end

   // Alternate sources reach only the pins that carry them
   always_comb begin
      pins.alt = `RST_PINS;
      pins.alt[`PIN_P2_0] = timer_zero_match_out;
      pins.alt[`PIN_P2_6] = clk_out_src;
   end
   assign pins.dout = pin_dout;

   pin_drive pin_drive_i (
      .clk(clk),
      .srst(srst),
      .pins(pins)
   );

   // Pad controls pass out of the driver's flip-flops unchanged
   assign pad_out = pins.pad_out;
   assign pad_oe = pins.pad_oe;
   assign pad_pu = pins.pad_pu;
   assign pad_pd = pins.pad_pd;
   assign pad_ana = pins.pad_ana;
   assign pad_ibuf_en = pins.ibuf_en;

   // Sampled pad levels and their previous value for edge sensing
   always_ff @(posedge clk) begin
      if (srst) begin
         pin_din <= `RST_PINS;
         din_prev <= `RST_PINS;
      end else begin
         pin_din <= pad_in;
         din_prev <= pin_din;
      end
   end

   for (genvar s = 0; s < `NUM_SRC; s++) begin : g_src
      // Only the two input codes sense; output and analog do not
      assign sensing[s] = ~port0_pin_mode[2*s+1];
      assign fall[s] = sensing[s] & din_prev[`PIN_P0_0+s] & ~pin_din[`PIN_P0_0+s];
   end

   // Configuration registers, written at the completing edge
   always_ff @(posedge clk) begin
      if (srst) begin
         port0_pin_mode <= `RST_MODE;
         port1_pin_control <= `RST_BYTE;
         port2_upper_pin_control <= `RST_P2HI;
         port2_lower_pin_control <= `RST_BYTE;
         evt_mask <= `RST_EVT;
      end else if (wr_fire && lane0) begin
         if (avs_address == a_p0mode) begin
            port0_pin_mode <= wbyte[3:0];
         end
         if (avs_address == a_p1ctl) begin
            // Bits 5..4 do not exist and stay zero
            port1_pin_control <= {wbyte[`P1_OD1_BIT:`P1_OD0_BIT], 2'b00, wbyte[3:0]};
         end
         if (avs_address == a_p2hi) begin
            port2_upper_pin_control <= wbyte[6:0];
         end
         if (avs_address == a_p2lo) begin
            port2_lower_pin_control <= wbyte;
         end
         if (avs_address == a_mask) begin
            evt_mask <= wbyte[`NUM_SRC-1:0];
         end
      end
   end

   // Enable bits of the flag register
   always_ff @(posedge clk) begin
      if (srst) begin
         port0_ext_irq_flags[`BIT_EN1] <= 1'b0;
         port0_ext_irq_flags[`BIT_EN0] <= 1'b0;
      end else if (wr_fire && lane0 && avs_address == a_p0flags) begin
         port0_ext_irq_flags[`BIT_EN1] <= wbyte[`BIT_EN1];
         port0_ext_irq_flags[`BIT_EN0] <= wbyte[`BIT_EN0];
      end
   end

   // Pending flags: an edge wins over a clearing write in the same cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         port0_ext_irq_flags[`BIT_PEND1] <= 1'b0;
         port0_ext_irq_flags[`BIT_PEND0] <= 1'b0;
      end else begin
         if (fall[1]) begin
            port0_ext_irq_flags[`BIT_PEND1] <= 1'b1;
         end else if (wr_fire && lane0 && avs_address == a_p0flags && !wbyte[`BIT_PEND1]) begin
            port0_ext_irq_flags[`BIT_PEND1] <= 1'b0;
         end
         if (fall[0]) begin
            port0_ext_irq_flags[`BIT_PEND0] <= 1'b1;
         end else if (wr_fire && lane0 && avs_address == a_p0flags && !wbyte[`BIT_PEND0]) begin
            port0_ext_irq_flags[`BIT_PEND0] <= 1'b0;
         end
      end
   end

   // Sticky event status, cleared by a completed read of it
   always_ff @(posedge clk) begin
      if (srst) begin
         evt_status <= `RST_EVT;
      end else if (fire && avs_read && avs_address == a_stat) begin
         evt_status <= fall;
      end else begin
         evt_status <= evt_status | fall;
      end
   end

   // request while pending and enabled; flag stays until software
   // clears it, so a missed clear keeps the request up
   always_ff @(posedge clk) begin
      if (srst) begin
         ext_req <= 1'b0;
         irq <= 1'b0;
      end else begin
         ext_req <= (port0_ext_irq_flags[`BIT_PEND1] & port0_ext_irq_flags[`BIT_EN1])
                  | (port0_ext_irq_flags[`BIT_PEND0] & port0_ext_irq_flags[`BIT_EN0]);
         irq <= |(evt_status & evt_mask);
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      next_readdata = `RST_WORD;
      case (avs_address)
         a_p0mode: next_readdata[3:0] = port0_pin_mode;
         a_p0flags: next_readdata[3:0] = port0_ext_irq_flags;
         a_p1ctl: next_readdata[7:0] = port1_pin_control;
         a_p2hi: next_readdata[6:0] = port2_upper_pin_control;
         a_p2lo: next_readdata[7:0] = port2_lower_pin_control;
         a_stat: next_readdata[`NUM_SRC-1:0] = evt_status;
         a_mask: next_readdata[`NUM_SRC-1:0] = evt_mask;
         default: next_readdata = `RST_WORD;
      endcase
   end

   // One wait cycle per access keeps read data a plain register
   always_ff @(posedge clk) begin
      if (srst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= `RST_WORD;
      end else if (req && avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
         avs_readdata <= next_readdata;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   pend0_set_a: assert property (fall[0] |=> port0_ext_irq_flags[`BIT_PEND0])
      else $error("pending zero not set by edge");
   pend0_clear_a: assert property (wr_fire && lane0 && avs_address == a_p0flags
      && !wbyte[`BIT_PEND0] && !fall[0] |=> !port0_ext_irq_flags[`BIT_PEND0])
      else $error("pending zero not cleared by write");
   pend1_keep_a: assert property (wr_fire && avs_address == a_p0flags && wbyte[`BIT_PEND1]
      && port0_ext_irq_flags[`BIT_PEND1] |=> port0_ext_irq_flags[`BIT_PEND1])
      else $error("pending one lost on write of one");
   req_enable_a: assert property (port0_ext_irq_flags[`BIT_PEND1] && port0_ext_irq_flags[`BIT_EN1]
      |=> ext_req)
      else $error("request missing for enabled source one");
   req_disable_a: assert property (!port0_ext_irq_flags[`BIT_EN0] && !port0_ext_irq_flags[`BIT_EN1]
      |=> !ext_req)
      else $error("request raised while disabled");
   p0_analog_a: assert property (port0_pin_mode[`P0_PIN1_F] == `M2_11
      |=> pad_ana[`PIN_P0_1] && !pad_ibuf_en[`PIN_P0_1] && !pad_oe[`PIN_P0_1])
      else $error("port 0 pin 1 analog mode wrong");
   p0_output_a: assert property (port0_pin_mode[`P0_PIN0_F] == `M2_10
      |=> pad_oe[`PIN_P0_0] && pad_out[`PIN_P0_0] == $past(pin_dout[`PIN_P0_0]))
      else $error("port 0 pin 0 push-pull wrong");
   p1_drain_a: assert property (port1_pin_control[`P1_OD1_BIT] && port1_pin_control[`P1_PIN1_F] == `M2_10
      |=> !pad_out[`PIN_P1_1] && pad_oe[`PIN_P1_1] == !$past(pin_dout[`PIN_P1_1]))
      else $error("port 1 pin 1 open drain wrong");
   p1_pulldown_a: assert property (port1_pin_control[`P1_PIN0_F] == `M2_11
      |=> pad_pd[`PIN_P1_0] && !pad_oe[`PIN_P1_0])
      else $error("port 1 pin 0 pull-down missing");
   p2_clock_a: assert property (port2_upper_pin_control[`P2H_PIN6_F] == `M3_CLK
      |=> pad_oe[`PIN_P2_6] && pad_out[`PIN_P2_6] == $past(clk_out_src))
      else $error("clock output not on pin 6");
   p2_timer_a: assert property (port2_lower_pin_control[`P2L_PIN0_F] == `M2_11
      |=> pad_oe[`PIN_P2_0] && pad_out[`PIN_P2_0] == $past(timer_zero_match_out))
      else $error("timer match not on pin 0");
   p2_pullup_a: assert property (port2_lower_pin_control[`P2L_PIN3_F] == `M2_00
      |=> pad_pu[`PIN_P2_3] && !pad_oe[`PIN_P2_3])
      else $error("port 2 pin 3 pull-up missing");
   p2_drain_a: assert property (port2_upper_pin_control[`P2H_PIN5_F] == `M2_11
      |=> !pad_out[`PIN_P2_5] && !pad_pu[`PIN_P2_5])
      else $error("port 2 pin 5 open drain wrong");
   bus_answer_a: assert property (req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not one cycle");

   edge_req_c: cover property (fall[0] && port0_ext_irq_flags[`BIT_EN0] ##2 ext_req);
   status_read_c: cover property (fire && avs_read && avs_address == a_stat && evt_status != `RST_EVT);
   clock_mode_c: cover property (port2_upper_pin_control[`P2H_PIN6_F] == `M3_CLK ##1 pad_oe[`PIN_P2_6]);
endmodule : port_config_ext_int

// >>> tb/pad_board.sv
// Board model on the pads of the port block.
// Assumes the bench sets which pins the board drives and to what level.
`timescale 1ns/1ps
module pad_board (
   input wire logic clk, // System clock
   input wire logic [10:0] pad_out, // Pad drive level
   input wire logic [10:0] pad_oe, // Pad drive enable
   input wire logic [10:0] pad_pu, // Pull-up enables
   input wire logic [10:0] pad_pd, // Pull-down enables
   input wire logic [10:0] board_en, // Board drives pin
   input wire logic [10:0] board_val, // Board level
   output logic [10:0] pad_in // Resolved pad level
);
   // Device drive wins, then board, then pulls; a floating pin reads the
   // inverse of pad_out, which is zero while undriven, so an unpulled pin reads high
   always_ff @(posedge clk) begin
      pad_in <= (pad_oe & pad_out) | (~pad_oe & board_en & board_val)
         | (~pad_oe & ~board_en & (pad_pu | (~pad_pd & ~pad_out)));
   end
endmodule : pad_board

// >>> tb/tb_port_config_ext_int.sv
// Self-checking bench for the port configuration block.
// Assumes one 40 MHz clock and a board model on the pads.
`timescale 1ns/1ps
module tb_port_config_ext_int;
   logic clk = 0, srst = 1, rd = 0, wr = 0, tmr = 1, cks = 1, ext_req, irq, wq;
   logic [9:0] adr = '0;
   logic [31:0] wd = '0, rdat, q;
   logic [10:0] po, oe, pu, pd, ana, ibe, pin, din, dout = '0, ben = 11'h003, bval = 11'h003;
   logic [3:0] be = 4'hf;
   int failures = 0, checks_done = 0;
   // 25 ns clock
   always #12.5 clk = ~clk;
   port_config_ext_int port_config_ext_int_i (.clk(clk), .srst(srst), .avs_address(adr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
      .avs_readdata(rdat), .avs_waitrequest(wq), .pad_in(pin), .pad_out(po), .pad_oe(oe),
      .pad_pu(pu), .pad_pd(pd), .pad_ana(ana), .pad_ibuf_en(ibe), .pin_din(din),
      .pin_dout(dout), .timer_zero_match_out(tmr), .clk_out_src(cks), .ext_req(ext_req),
      .irq(irq));
   pad_board pad_board_i (.clk(clk), .pad_out(po), .pad_oe(oe), .pad_pu(pu), .pad_pd(pd),
      .board_en(ben), .board_val(bval), .pad_in(pin));
   task automatic give_verdict;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // One bus access; held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
      int n;
      n = 0;
      adr <= a;
      wr <= w;
      rd <= !w;
      wd <= {24'h0, d};
      @(posedge clk);
      while (wq !== 1'b0) begin
         if (++n > 50) begin
            failures++;
            give_verdict();
         end
         @(posedge clk);
      end
      q = rdat;
      rd <= 0;
      wr <= 0;
      // An idle edge keeps the next request out of this time step
      @(posedge clk);
   endtask : bus
   task automatic rchk(input logic [9:0] a, input logic [7:0] e);
      bus(0, a, 8'h00);
      chk("readdata", {24'h0, e}, q);
   endtask : rchk
   task automatic t_reset;
      logic [9:0] al[8] = '{10'h39c, 10'h3a0, 10'h3a4, 10'h3a8, 10'h3ac, 10'h380, 10'h384, 10'h3f0};
      foreach (al[i]) rchk(al[i], 8'h00);
      chk("pad_pu", 11'h7f0, pu);
      $display("reset test done");
   endtask : t_reset
   task automatic t_port1;
      bus(1, 10'h3a4, 8'hce);
      dout <= 11'h004;
      repeat (3) @(posedge clk);
      rchk(10'h3a4, 8'hce);
      chk("p1 pd", 1, pd[3]);
      chk("p1 od", 2'b00, {oe[2], po[2]});
      dout <= 11'h000;
      repeat (2) @(posedge clk);
      chk("p1 od low", 1, oe[2]);
      bus(1, 10'h3a4, 8'h8b);
      dout <= 11'h008;
      repeat (2) @(posedge clk);
      chk("p1 od1 pd0", 4'b0010, {oe[3], po[3], pd[2], oe[2]});
      bus(1, 10'h3a4, 8'h0b);
      repeat (2) @(posedge clk);
      chk("p1 pp1", 2'b11, {oe[3], po[3]});
      $display("port1 test done");
   endtask : t_port1
   task automatic t_port2;
      bus(1, 10'h3ac, 8'hdb);
      bus(1, 10'h3a8, 8'h7e);
      repeat (2) @(posedge clk);
      chk("p2 oe", 7'h7b, oe[10:4]);
      chk("p2 alt", 2'b11, {po[10], po[4]});
      bus(1, 10'h3a8, 8'h20);
      repeat (2) @(posedge clk);
      chk("p2 ana", 2'b10, {ana[10], ibe[10]});
      // A write without the low byte lane must not land
      be <= 4'he;
      bus(1, 10'h3a8, 8'h00);
      be <= 4'hf;
      rchk(10'h3a8, 8'h20);
      $display("port2 test done");
   endtask : t_port2
   task automatic t_irq;
      bus(1, 10'h3a0, 8'h02);
      bus(1, 10'h384, 8'h03);
      bval <= 11'h002;
      repeat (5) @(posedge clk);
      chk("req", 2'b11, {ext_req, irq});
      bval <= 11'h000;
      repeat (5) @(posedge clk);
      rchk(10'h3a0, 8'h07);
      bus(1, 10'h3a0, 8'h06);
      rchk(10'h3a0, 8'h06);
      chk("req off", 0, ext_req);
      bus(1, 10'h3a0, 8'h0e);
      repeat (2) @(posedge clk);
      chk("req en1", 1, ext_req);
      bus(1, 10'h3a0, 8'h0a);
      rchk(10'h3a0, 8'h0a);
      chk("req cleared", 0, ext_req);
      rchk(10'h380, 8'h03);
      rchk(10'h380, 8'h00);
      repeat (2) @(posedge clk);
      chk("irq off", 0, irq);
      $display("irq test done");
   endtask : t_irq
   // Port 0: pin 0 push-pull, pin 1 analog; a fall on an analog pin is not sensed
   task automatic t_port0;
      dout <= 11'h001;
      bus(1, 10'h39c, 8'h0e);
      bval <= 11'h001;
      repeat (4) @(posedge clk);
      chk("p0 pads", 4'b1011, {ana[1], ibe[1], oe[0], po[0]});
      chk("p0 din", 2'b01, din[1:0]);
      rchk(10'h39c, 8'h0e);
      rchk(10'h3a0, 8'h00);
      bval <= 11'h003;
      bus(1, 10'h39c, 8'h00);
      dout <= 11'h000;
      repeat (4) @(posedge clk);
      $display("port0 test done");
   endtask : t_port0
   initial begin
      repeat (20) @(posedge clk);
      srst <= 0;
      @(posedge clk);
      t_reset();
      t_port1();
      t_port2();
      t_port0();
      t_irq();
      give_verdict();
   end
endmodule : tb_port_config_ext_int
